//--- rtl/swap_step_pkg.sv
// Package for the exchange-and-step instruction unit.
// Assumes 10-bit instruction words and 4-bit data paths.
package swap_step_pkg;
    // ------------------------------------------------------------
    // Instruction encodings
    // ------------------------------------------------------------
    localparam logic [5:0] op_step_up = 6'h2e;   // Upper six bits, 2E0-2EF
    localparam logic [5:0] op_step_down = 6'h2f; // Upper six bits, 2F0-2FF
    localparam int op_lsb = 4;                   // Opcode field position
    localparam int imm_lsb = 0;                  // Immediate field position
    // ------------------------------------------------------------
    // Reset values and wrap points
    // ------------------------------------------------------------
    localparam logic [3:0] nib_reset = 4'h0;     // Register reset value
    localparam logic [3:0] wrap_up = 4'h0;       // Skip value after increment
    localparam logic [3:0] wrap_down = 4'hf;     // Skip value after decrement
    localparam logic [3:0] nib_one = 4'h1;       // Step size
endpackage

//--- rtl/swap_step_decode.sv
// Decoder for the two exchange-and-step instruction words.
// Assumes a registered instruction word from the same clock domain.
`timescale 1ns/100ps
`default_nettype none
module swap_step_decode (
    // Instruction word
    input wire logic [9:0] instr,
    // Decoded strobes and immediate
    output logic is_up,
    output logic is_down,
    output logic [3:0] imm
);
    // ------------------------------------------------------------
    // Pattern match on upper bits
    // ------------------------------------------------------------
    // Upper six bits pick the form, low four carry the operand
    assign is_up = (instr[9:swap_step_pkg::op_lsb]
        == swap_step_pkg::op_step_up);
    assign is_down = (instr[9:swap_step_pkg::op_lsb]
        == swap_step_pkg::op_step_down);
    assign imm = instr[swap_step_pkg::imm_lsb +: 4];
endmodule // swap_step_decode
`default_nettype wire

//--- rtl/ram_exchange_step.sv
// Execution unit for the swap-and-step instructions of a nibble core.
// Assumes the sequencer presents one word per instruction cycle with
// exec high, and that RAM at ram_pointer reads combinationally.
`timescale 1ns/100ps
`default_nettype none
module ram_exchange_step (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Instruction issue
    input wire logic exec,
    input wire logic [9:0] instr,
    // RAM at the data pointer
    input wire logic [3:0] ram_rdata,
    output logic ram_we,
    output logic [3:0] ram_wdata,
    // Carry flag, passed through untouched
    input wire logic carry_in,
    output logic carry_flag,
    // Register file
    output logic [3:0] acc,
    output logic [3:0] col,
    output logic [3:0] digit,
    // Skip request for the next word
    output logic skip
);
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic is_up; // Increment form
    logic is_down; // Decrement form
    logic [3:0] imm; // Immediate operand
    logic do_up; // Increment form issued
    logic do_down; // Decrement form issued

    swap_step_decode u_dec (
        .instr(instr),
        .is_up(is_up),
        .is_down(is_down),
        .imm(imm)
    );

    // Decoded forms only count while exec marks the word valid
    assign do_up = exec & is_up;
    assign do_down = exec & is_down;

    // ------------------------------------------------------------
    // Execution state
    // ------------------------------------------------------------
    // Two states keep the structure; every word retires in one cycle
    typedef enum logic {st_idle, st_run} state_t;
    state_t state; // Idle until first instruction
    state_t next_state;
    logic [3:0] next_acc;
    logic [3:0] next_col;
    logic [3:0] next_digit;
    logic next_skip;
    logic [3:0] stepped; // Digit after the step
    logic [3:0] stepped_up;
    logic [3:0] stepped_down;

    // Write to RAM in the same cycle so the swap reads old data
    assign ram_we = do_up | do_down;
    assign ram_wdata = acc;
    // Carry is never written by these instructions
    assign carry_flag = carry_in;

    // Next-value computation, single cycle per word
    always_comb begin
        stepped_up = digit + swap_step_pkg::nib_one;
        stepped_down = digit - swap_step_pkg::nib_one;
        stepped = digit;
        next_acc = acc;
        next_col = col;
        next_digit = digit;
        next_skip = 1'b0;
        next_state = state;
        case (state)
            st_idle, st_run: begin
                if (do_up || do_down) begin
                    next_state = st_run;
                    // Swap: old memory into accumulator
                    next_acc = ram_rdata;
                    next_col = col ^ imm;
                    if (do_up) begin
                        stepped = stepped_up;
                        next_skip = (stepped_up
                            == swap_step_pkg::wrap_up);
                    end else begin
                        stepped = stepped_down;
                        next_skip = (stepped_down
                            == swap_step_pkg::wrap_down);
                    end
                    next_digit = stepped;
                end
            end
            default: begin
                // Unreachable encodings fall back to idle
                next_state = st_idle;
            end
        endcase
    end

    // Registers only; one edge retires one word
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state <= st_idle;
            acc <= swap_step_pkg::nib_reset;
            col <= swap_step_pkg::nib_reset;
            digit <= swap_step_pkg::nib_reset;
            skip <= 1'b0;
        end else begin
            state <= next_state;
            acc <= next_acc;
            col <= next_col;
            digit <= next_digit;
            skip <= next_skip;
        end
    end

    // ------------------------------------------------------------
    // Check helpers
    // ------------------------------------------------------------
    // Opcode match written apart from the decoder, so a decoder fault
    // shows up in the checks instead of agreeing with itself
    function automatic logic swap_word(input logic [9:0] w);
        return (w[9:swap_step_pkg::op_lsb] == swap_step_pkg::op_step_up)
            || (w[9:swap_step_pkg::op_lsb] == swap_step_pkg::op_step_down);
    endfunction

    logic word_hit; // Either form presented with exec
    logic [3:0] last_taken; // Nibble the previous swap took from RAM
    logic [3:0] next_last_taken;
    logic taken_valid; // At least one swap since reset
    logic next_taken_valid;

    assign word_hit = exec && swap_word(instr);

    // Remember what each swap pulled out of memory
    always_comb begin
        next_last_taken = last_taken;
        next_taken_valid = taken_valid;
        if (word_hit) begin
            // Only a swap may move the accumulator
            next_last_taken = ram_rdata;
            next_taken_valid = 1'b1;
        end
    end

    // Helper registers; cleared with the unit
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            last_taken <= swap_step_pkg::nib_reset;
            taken_valid <= 1'b0;
        end else begin
            last_taken <= next_last_taken;
            taken_valid <= next_taken_valid;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // One clock domain, so clocking and disable are given once
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    swap_acc_a: assert property ((do_up | do_down) |=>
        acc == $past(ram_rdata))
        else $error("accumulator did not take memory");
    swap_ram_a: assert property ((do_up | do_down) |->
        ram_we && ram_wdata == acc)
        else $error("memory not written with accumulator");
    col_xor_a: assert property (do_up |=>
        col == ($past(col) ^ $past(instr[3:0])))
        else $error("column xor wrong");
    col_down_a: assert property (do_down |=>
        col == ($past(col) ^ $past(instr[3:0])))
        else $error("column xor wrong on down form");
    step_up_a: assert property (do_up |=>
        digit == $past(digit) + 4'h1 && skip == (digit == 4'h0))
        else $error("increment or skip wrong");
    step_down_a: assert property (do_down |=>
        digit == $past(digit) - 4'h1 && skip == (digit == 4'hf))
        else $error("decrement or skip wrong");
    decode_up_a: assert property (exec && instr[9:4] == 6'h2e
        |-> ram_we)
        else $error("2Ex not decoded");
    carry_keep_a: assert property (carry_flag == carry_in)
        else $error("carry modified");
    idle_hold_a: assert property (!(do_up | do_down) |=>
        $stable(digit) && $stable(acc) && $stable(col) && !skip)
        else $error("state changed without instruction");

    // Checks against the independent opcode match and helper
    swap_back_a: assert property (word_hit && taken_valid |->
        ram_wdata == last_taken)
        else $error("memory not given the nibble taken before");
    decode_down_a: assert property (exec && instr[9:4] == 6'h2f
        |-> ram_we)
        else $error("2Fx not decoded");
    refuse_write_a: assert property (!word_hit |-> !ram_we)
        else $error("memory written by a foreign word");
    refuse_keep_a: assert property (!word_hit |=>
        !skip && $stable(acc) && $stable(col) && $stable(digit))
        else $error("foreign word changed the registers");
    skip_cause_a: assert property (skip |-> $past(word_hit))
        else $error("skip raised without a step");
    // Reset is checked with the disable lifted on purpose
    reset_zero_a: assert property (disable iff (1'b0)
        $rose(resetn) |-> acc == swap_step_pkg::nib_reset
        && col == swap_step_pkg::nib_reset
        && digit == swap_step_pkg::nib_reset && !skip)
        else $error("registers not cleared by reset");

    // Main scenarios: wrap both ways, back to back, refused word
    up_wrap_c: cover property (do_up && digit == 4'hf);
    down_wrap_c: cover property (do_down && digit == 4'h0);
    back_to_back_c: cover property (do_up ##1 do_down);
    refused_c: cover property (exec && !word_hit);
endmodule // ram_exchange_step
`default_nettype wire

//--- verification/ram_exchange_step_bench.sv
// Self-checking bench for the swap-and-step execution unit.
// Assumes the unit carries its own assertions; RAM is driven here.
`timescale 1ns/100ps
`default_nettype none
module ram_exchange_step_bench;
    // ----------------------------------------
    // Ports, model state, counters
    // ----------------------------------------
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic exec = 1'b0;
    logic [9:0] instr = 10'h000;
    logic [3:0] ram_rdata = 4'h0;
    logic carry_in = 1'b0;
    logic ram_we, carry_flag, skip;
    logic [3:0] ram_wdata, acc, col, digit;
    // Expected outputs of one issued word
    typedef struct {logic we; logic [3:0] wd; logic cf;
        logic [3:0] a, c, d; logic sk;} note_t;
    note_t q[$];
    note_t pend, n;
    logic pv = 1'b0;
    // Model registers: accumulator, column, digit
    logic [3:0] ma = 4'h0, mc = 4'h0, md = 4'h0;
    logic [15:0] seed = 16'h000f;
    int err_count = 0;
    int comparisons = 0;
    // 200 MHz clock
    always #2.5 mclk = ~mclk;
    ram_exchange_step DUT (.mclk(mclk), .resetn(resetn), .exec(exec),
        .instr(instr), .ram_rdata(ram_rdata), .ram_we(ram_we),
        .ram_wdata(ram_wdata), .carry_in(carry_in),
        .carry_flag(carry_flag), .acc(acc), .col(col), .digit(digit),
        .skip(skip));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic check(input logic [3:0] got, input logic [3:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Drive one word at the edge; random RAM data and carry
    task automatic issue(input logic e, input logic [9:0] w);
        logic hit;
        note_t t;
        @(posedge mclk);
        seed = lfsr(seed);
        exec <= e;
        instr <= w;
        ram_rdata <= seed[3:0];
        carry_in <= seed[4];
        hit = e && (w[9:4] == swap_step_pkg::op_step_up
            || w[9:4] == swap_step_pkg::op_step_down);
        t.we = hit;
        t.wd = ma;
        t.cf = seed[4];
        t.sk = 1'b0;
        if (hit) begin
            ma = seed[3:0];
            mc = mc ^ w[3:0];
            // Bit 4 set means the down form
            md = w[4] ? md - 4'h1 : md + 4'h1;
            t.sk = (md == (w[4] ? 4'hf : 4'h0));
        end
        t.a = ma;
        t.c = mc;
        t.d = md;
        q.push_back(t);
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // ----------------------------------------
    // Monitor: combinational now, registers one cycle later
    // ----------------------------------------
    always @(negedge mclk) begin
        if (resetn && q.size() > 0) begin
            if (pv) begin
                check(acc, pend.a);
                check(col, pend.c);
                check(digit, pend.d);
                check({3'h0, skip}, {3'h0, pend.sk});
            end
            n = q.pop_front();
            check({3'h0, ram_we}, {3'h0, n.we});
            if (n.we) check(ram_wdata, n.wd);
            check({3'h0, carry_flag}, {3'h0, n.cf});
            pend = n;
            pv = 1'b1;
        end
    end
    // Main sequence: wrap both ways back to back, then random mix
    initial begin
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        for (int i = 0; i < 17; i++)
            issue(1'b1, {swap_step_pkg::op_step_up, i[3:0]});
        for (int i = 0; i < 17; i++)
            issue(1'b1, {swap_step_pkg::op_step_down, i[3:0]});
        for (int i = 0; i < 200; i++) begin
            case (seed[6:5])
                2'h0: issue(1'b1, {swap_step_pkg::op_step_up, seed[3:0]});
                2'h1: issue(1'b1, {swap_step_pkg::op_step_down, seed[3:0]});
                2'h2: issue(1'b1, {6'h2d, seed[3:0]});
                default: issue(1'b0, {swap_step_pkg::op_step_up, seed[3:0]});
            endcase
        end
        issue(1'b0, 10'h000);
        issue(1'b0, 10'h000);
        end_sim;
    end
    // Watchdog well beyond the ~240 cycles the tests need
    initial begin
        #5000;
        err_count++;
        end_sim;
    end
endmodule // ram_exchange_step_bench
`default_nettype wire
